// [design/port_g_pin_interrupt_unit.sv]
// Port G pin interrupt unit: Wishbone register file, per-line detectors and interrupt output
//
// The Wishbone interface to the registers is this design's own decision.
`timescale 1ns/1ps
`include "port_g_map.svh"
module port_g_pin_interrupt_unit (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [18:0] pin_g_i,
  input wire logic slow_oscillator_i,
  input wire logic fast_oscillator_i,
  output logic irq_o
);

  port_g_pkg::unit_state_t st;
  port_g_pkg::unit_state_t nx;
  logic [18:0] set_vec;
  logic [75:0] modes;
  logic [31:0] rdata;
  logic [31:0] lane;
  logic [11:0] word_adr;
  logic req;
  logic commit;
  logic [18:0] clr;

  line_sample_if smp ();

  // ****************************************
  // Sampling stage
  // ****************************************
  sampling_tick_gen sampling_tick_gen_i (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .slow_oscillator_i(slow_oscillator_i),
    .fast_oscillator_i(fast_oscillator_i),
    .clk_sel_i(st.clk_sel),
    .prescale_i(st.prescale),
    .pin_g_i(pin_g_i),
    .smp(smp)
  );

  // ****************************************
  // Per-line trigger detection
  // ****************************************
  // lines 16-18, lines 8-15, lines 0-7
  assign modes = {st.trig_hi, st.trig_mid, st.trig_lo};

  genvar g;
  generate
    for (g = 0; g < `LINE_COUNT; g++) begin : g_line
      line_trigger_detect #(
        .LINE(g)
      ) line_trigger_detect_i (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .mode_i(modes[4*g +: 4]),
        .smp(smp),
        .set_o(set_vec[g])
      );
    end
  endgenerate

  // ****************************************
  // Register read mux
  // ****************************************
  assign word_adr = {wb_adr_i[11:2], 2'b00};
  assign lane = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  always_comb begin
    unique case (word_adr)
      `OFS_TRIG_0_7: rdata = st.trig_lo;
      `OFS_TRIG_8_15: rdata = st.trig_mid;
      `OFS_TRIG_16_18: rdata = {20'h00000, st.trig_hi};
      `OFS_LINE_EN: rdata = {13'h0000, st.en};
      `OFS_LINE_PEND: rdata = {13'h0000, st.pend};
      `OFS_SAMPLE_CLK: rdata = {25'h0000000, st.prescale, 3'h0, st.clk_sel};
      default: rdata = 32'h0000_0000;
    endcase
  end

  // ****************************************
  // Bus slave and register update
  // ****************************************
  assign req = wb_cyc_i & wb_stb_i;
  assign commit = req & st.ack & wb_we_i;

  always_comb begin
    nx = st;
    nx.ack = 1'b0;
    clr = 19'h00000;
    if (req && !st.ack) begin
      nx.ack = 1'b1;
      nx.dat = rdata;
    end
    if (commit) begin
      unique case (word_adr)
        `OFS_TRIG_0_7: nx.trig_lo = (st.trig_lo & ~lane) | (wb_dat_i & lane);
        `OFS_TRIG_8_15: nx.trig_mid = (st.trig_mid & ~lane) | (wb_dat_i & lane);
        `OFS_TRIG_16_18: nx.trig_hi = (st.trig_hi & ~lane[11:0]) | (wb_dat_i[11:0] & lane[11:0]);
        `OFS_LINE_EN: nx.en = (st.en & ~lane[18:0]) | (wb_dat_i[18:0] & lane[18:0]);
        `OFS_LINE_PEND: clr = wb_dat_i[18:0] & lane[18:0];
        `OFS_SAMPLE_CLK: begin
          if (wb_sel_i[0]) begin
            nx.prescale = wb_dat_i[`PRESCALE_MSB:`PRESCALE_LSB];
            nx.clk_sel = wb_dat_i[`CLK_SELECT_BIT];
          end
        end
        default: nx.dat = st.dat;
      endcase
    end
    // new trigger wins over a clear in the same cycle
    nx.pend = (st.pend & ~clr) | set_vec;
    nx.irq = |(nx.pend & nx.en);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= nx;
    end
  end

  assign wb_ack_o = st.ack;
  assign wb_dat_o = st.dat;
  assign irq_o = st.irq;

  // ****************************************
  // Checks
  // ****************************************
  sequence s_read_req(logic [11:0] a);
    req && !st.ack && !wb_we_i && word_adr == a;
  endsequence

  sequence s_pend_write;
    commit && word_adr == `OFS_LINE_PEND;
  endsequence

  AST_RESET_ZERO: assert property (@(posedge clk_i)
    rst_i |=> (st.trig_lo == `RESET_WORD && st.trig_mid == `RESET_WORD && st.trig_hi == 12'h000
      && st.en == 19'h00000 && st.pend == 19'h00000 && !irq_o))
    else $error("registers not zero after reset");

  AST_EN_READBACK: assert property (@(posedge clk_i) disable iff (rst_i)
    s_read_req(`OFS_LINE_EN) |=> (wb_ack_o && wb_dat_o == {13'h0000, $past(st.en)}))
    else $error("enable readback wrong");

  AST_PEND_READBACK: assert property (@(posedge clk_i) disable iff (rst_i)
    s_read_req(`OFS_LINE_PEND) |=> (wb_ack_o && wb_dat_o[31:19] == 13'h0000))
    else $error("pending upper bits not zero");

  AST_W1C_CLEARS: assert property (@(posedge clk_i) disable iff (rst_i)
    (s_pend_write and (wb_sel_i == 4'hf)) |=>
      ((st.pend & $past(wb_dat_i[18:0]) & ~$past(set_vec)) == 19'h00000))
    else $error("write one did not clear pending flag");

  AST_W0_KEEPS: assert property (@(posedge clk_i) disable iff (rst_i)
    s_pend_write |=> (($past(st.pend) & ~$past(wb_dat_i[18:0]) & ~st.pend) == 19'h00000))
    else $error("write zero disturbed pending flag");

  AST_SET_PENDS: assert property (@(posedge clk_i) disable iff (rst_i)
    (|set_vec) |=> ((st.pend & $past(set_vec)) == $past(set_vec)))
    else $error("trigger did not set pending flag");

  AST_IRQ_LEVEL: assert property (@(posedge clk_i) disable iff (rst_i)
    irq_o == |(st.pend & st.en))
    else $error("interrupt output disagrees with enabled pending flags");

  AST_LINE7_FIELD: assert property (@(posedge clk_i) disable iff (rst_i)
    (commit && word_adr == `OFS_TRIG_0_7 && wb_sel_i[3]) |=> (modes[31:28] == $past(wb_dat_i[31:28])))
    else $error("line 7 mode field misplaced");

  AST_LINE8_FIELD: assert property (@(posedge clk_i) disable iff (rst_i)
    (commit && word_adr == `OFS_TRIG_8_15 && wb_sel_i[0]) |=> (modes[35:32] == $past(wb_dat_i[3:0])))
    else $error("line 8 mode field misplaced");

  AST_HI_UNUSED: assert property (@(posedge clk_i) disable iff (rst_i)
    s_read_req(`OFS_TRIG_16_18) |=> (wb_dat_o[31:12] == 20'h00000))
    else $error("unused mode bits read nonzero");

  AST_CLK_SELECT_STORE: assert property (@(posedge clk_i) disable iff (rst_i)
    (commit && word_adr == `OFS_SAMPLE_CLK && wb_sel_i[0]) |=> (st.clk_sel == $past(wb_dat_i[0])))
    else $error("sampling clock select not stored");

endmodule

// [pkg/port_g_map.svh]
// Register map, field positions, reset values and mode codes of the port G pin interrupt unit
// Functional notes
// - Four-bit mode per line: 0 rise, 1 fall, 2 high, 3 low, 4 both edges.
// - First mode word holds lines 0 to 7, line 7 in bits 31:28.
// - Second mode word holds lines 8 to 15, line 8 in bits 3:0.
// - Third mode word holds lines 16 to 18 in bits 11:0; upper bits unused.
// - Enable word: one read/write bit per line, bits 0 to 18, upper bits zero.
// - Pending word: one flag per line, bits 0 to 18; one means pending.
// - Writing one clears a pending flag; writing zero leaves it alone.
// - After reset all mode, enable and pending words read zero.
// - Sampling clock select bit: zero slow oscillator, one fast oscillator.
// - Three-bit prescale n divides the chosen sampling clock by two to the n.
`ifndef PORT_G_MAP_SVH
`define PORT_G_MAP_SVH

`define LINE_COUNT 19
`define OFS_TRIG_0_7 12'h2c0
`define OFS_TRIG_8_15 12'h2c4
`define OFS_TRIG_16_18 12'h2c8
`define OFS_LINE_EN 12'h2d0
`define OFS_LINE_PEND 12'h2d4
`define OFS_SAMPLE_CLK 12'h2d8
`define TRIG_16_18_BITS 12
`define PRESCALE_LSB 4
`define PRESCALE_MSB 6
`define CLK_SELECT_BIT 0
`define RESET_WORD 32'h0000_0000
`define MODE_RISE 4'h0
`define MODE_FALL 4'h1
`define MODE_HIGH 4'h2
`define MODE_LOW 4'h3
`define MODE_BOTH 4'h4

`endif

// [pkg/port_g_pkg.sv]
// State types of the port G pin interrupt unit
package port_g_pkg;

  typedef struct packed {
    logic [31:0] trig_lo;
    logic [31:0] trig_mid;
    logic [11:0] trig_hi;
    logic [18:0] en;
    logic [18:0] pend;
    logic [2:0] prescale;
    logic clk_sel;
    logic ack;
    logic [31:0] dat;
    logic irq;
  } unit_state_t;

  typedef struct packed {
    logic [1:0] osc_a;
    logic [1:0] osc_b;
    logic [1:0] osc_d;
    logic [18:0] pin_a;
    logic [18:0] pin_b;
    logic [6:0] cnt;
    logic [18:0] cur;
    logic [18:0] prev;
    logic fresh;
  } tick_state_t;

endpackage

// [pkg/line_sample_if.sv]
// Sampled pin levels passed from the sampling stage to the trigger detectors
`timescale 1ns/1ps
interface line_sample_if;
  logic fresh;
  logic [18:0] cur;
  logic [18:0] prev;
  modport source (output fresh, output cur, output prev);
  modport sink (input fresh, input cur, input prev);
endinterface

// [design/sampling_tick_gen.sv]
// Sampling clock selection, prescaling and pin sampling
`timescale 1ns/1ps
`include "port_g_map.svh"
module sampling_tick_gen (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic slow_oscillator_i,
  input wire logic fast_oscillator_i,
  input wire logic clk_sel_i,
  input wire logic [2:0] prescale_i,
  input wire logic [18:0] pin_g_i,
  line_sample_if.source smp
);

  port_g_pkg::tick_state_t st;
  port_g_pkg::tick_state_t nx;
  logic edge_seen;
  logic [6:0] limit;
  logic tick;

  // ****************************************
  // Reference edge and prescaler
  // ****************************************
  always_comb begin
    nx = st;
    nx.osc_a = {slow_oscillator_i, fast_oscillator_i};
    nx.osc_b = st.osc_a;
    nx.osc_d = st.osc_b;
    nx.pin_a = pin_g_i;
    nx.pin_b = st.pin_a;
    edge_seen = clk_sel_i ? (st.osc_b[0] & ~st.osc_d[0]) : (st.osc_b[1] & ~st.osc_d[1]);
    // divide by two to the n
    limit = 7'((8'h01 << prescale_i) - 8'h01);
    tick = edge_seen && (st.cnt >= limit);
    if (edge_seen) begin
      nx.cnt = tick ? 7'h00 : 7'(st.cnt + 7'h01);
    end
    nx.fresh = tick;
    if (tick) begin
      nx.prev = st.cur;
      nx.cur = st.pin_b;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= nx;
    end
  end

  assign smp.fresh = st.fresh;
  assign smp.cur = st.cur;
  assign smp.prev = st.prev;

  // ****************************************
  // Checks
  // ****************************************
  AST_PRESCALE_COUNT: assert property (@(posedge clk_i) disable iff (rst_i)
    st.fresh |-> ($past(st.cnt) >= $past(limit)))
    else $error("sample taken before prescaled edge count reached");

endmodule

// [design/line_trigger_detect.sv]
// Trigger condition decode for one pin line
`timescale 1ns/1ps
`include "port_g_map.svh"
module line_trigger_detect #(
  parameter int LINE = 0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [3:0] mode_i,
  line_sample_if.sink smp,
  output logic set_o
);

  logic c;
  logic p;

  assign c = smp.cur[LINE];
  assign p = smp.prev[LINE];

  // mode decode, reserved codes stay silent
  always_comb begin
    set_o = 1'b0;
    if (smp.fresh) begin
      case (mode_i)
        `MODE_RISE: set_o = c & ~p;
        `MODE_FALL: set_o = ~c & p;
        `MODE_HIGH: set_o = c;
        `MODE_LOW: set_o = ~c;
        `MODE_BOTH: set_o = c ^ p;
        default: set_o = 1'b0;
      endcase
    end
  end

  AST_RESERVED_SILENT: assert property (@(posedge clk_i) disable iff (rst_i)
    (mode_i > `MODE_BOTH) |-> !set_o)
    else $error("reserved mode raised a trigger");

  AST_RISE_DETECT: assert property (@(posedge clk_i) disable iff (rst_i)
    (smp.fresh && mode_i == `MODE_RISE && c && !p) |-> set_o)
    else $error("rising edge missed");

endmodule

// [dv/pin_partner.sv]
// Far-side model: port G pin levels and the two sampling oscillators
`timescale 1ns/1ps
module pin_partner #(
  parameter int FAST_HALF_NS = 40,
  parameter int SLOW_HALF_NS = 200
) (
  input wire logic clk_i,
  input wire logic slow_run_i,
  output logic [18:0] pin_g_o,
  output logic slow_oscillator_o,
  output logic fast_oscillator_o
);
  initial begin
    pin_g_o = 19'h00000;
    slow_oscillator_o = 1'b0;
    fast_oscillator_o = 1'b0;
  end
  always #(FAST_HALF_NS) fast_oscillator_o = ~fast_oscillator_o;
  // slow source stands still unless told to run
  always #(SLOW_HALF_NS) begin
    if (slow_run_i) begin
      slow_oscillator_o = ~slow_oscillator_o;
    end
  end
  // Pins change just after a bus clock edge
  task set_pins(input logic [18:0] v);
    @(posedge clk_i);
    pin_g_o <= v;
  endtask
endmodule

// [dv/port_g_pin_interrupt_unit_test.sv]
// Self-checking bench of the port G pin interrupt unit
`timescale 1ns/1ps
`include "port_g_map.svh"
module port_g_pin_interrupt_unit_test;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic slow_run = 1'b0;
  logic [11:0] adr = 12'h000;
  logic [3:0] sel = 4'hf;
  logic [31:0] dat = 32'h0;
  logic [31:0] q;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic irq_o;
  logic slow;
  logic fast;
  logic [18:0] pins;
  int bad_count = 0;
  int num_checks = 0;
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin bad_count++; \
  $display("wrong value at %0t got %h expected %h", $time, a, b); end end

  always #5 clk_i = ~clk_i;

  port_g_pin_interrupt_unit port_g_pin_interrupt_unit_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .pin_g_i(pins), .slow_oscillator_i(slow), .fast_oscillator_i(fast), .irq_o(irq_o));
  pin_partner pin_partner_i (.clk_i(clk_i), .slow_run_i(slow_run), .pin_g_o(pins),
    .slow_oscillator_o(slow), .fast_oscillator_o(fast));

  // ****************
  // Bus and check tasks
  // ****************
  task wb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1 && ++n < 40);
    if (n >= 40) bad_count++;
    q = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    `CHK(q, e)
  endtask
  task poll(input logic [31:0] e);
    int n;
    n = 0;
    do wb(1'b0, `OFS_LINE_PEND, 32'h0); while (q !== e && ++n < 200);
    `CHK(q, e)
  endtask
  task conclude();
    if (bad_count == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ****************
  // Scenarios
  // ****************
  task t_reset();
    logic [11:0] a [6];
    a = '{`OFS_TRIG_0_7, `OFS_TRIG_8_15, `OFS_TRIG_16_18, `OFS_LINE_EN, `OFS_LINE_PEND, `OFS_SAMPLE_CLK};
    foreach (a[i]) rd(a[i], `RESET_WORD);
  endtask
  task t_fields();
    logic [11:0] a [4];
    logic [31:0] e [4];
    a = '{`OFS_TRIG_0_7, `OFS_TRIG_8_15, `OFS_TRIG_16_18, `OFS_LINE_EN};
    e = '{32'hffff_ffff, 32'hffff_ffff, 32'h0000_0fff, 32'h0007_ffff};
    foreach (a[i]) begin
      wb(1'b1, a[i], 32'hffff_ffff);
      rd(a[i], e[i]);
      wb(1'b1, a[i], 32'h0);
    end
    wb(1'b1, 12'h100, 32'hffff_ffff);
    rd(12'h100, 32'h0);
  endtask
  task t_select();
    pin_partner_i.set_pins(19'h00001);
    repeat (100) @(posedge clk_i);
    rd(`OFS_LINE_PEND, 32'h0);
    wb(1'b1, `OFS_SAMPLE_CLK, 32'h0000_0071);
    rd(`OFS_SAMPLE_CLK, 32'h0000_0071);
    wb(1'b1, `OFS_SAMPLE_CLK, 32'h0000_0001);
    poll(32'h0000_0001);
    pin_partner_i.set_pins(19'h00000);
    wb(1'b1, `OFS_LINE_PEND, 32'h0000_0001);
    poll(32'h0);
  endtask
  task t_modes();
    wb(1'b1, `OFS_TRIG_0_7, 32'h0f54_3210);
    wb(1'b1, `OFS_TRIG_8_15, 32'h0000_0001);
    wb(1'b1, `OFS_TRIG_16_18, 32'h0000_0200);
    wb(1'b1, `OFS_LINE_PEND, 32'h0007_ffff);
    poll(32'h0000_0008);
    pin_partner_i.set_pins(19'h4017f);
    poll(32'h0004_001d);
    wb(1'b1, `OFS_LINE_PEND, 32'h0);
    rd(`OFS_LINE_PEND, 32'h0004_001d);
    wb(1'b1, `OFS_LINE_PEND, 32'h0007_ffff);
    poll(32'h0004_0004);
    pin_partner_i.set_pins(19'h00000);
    poll(32'h0004_011e);
  endtask
  task t_irq();
    `CHK(irq_o, 1'b0)
    wb(1'b1, `OFS_LINE_EN, 32'h0000_0100);
    repeat (3) @(posedge clk_i);
    `CHK(irq_o, 1'b1)
    wb(1'b1, `OFS_LINE_PEND, 32'h0000_0100);
    repeat (3) @(posedge clk_i);
    `CHK(irq_o, 1'b0)
    rd(`OFS_LINE_PEND, 32'h0004_001e);
  endtask
  task t_slow();
    slow_run <= 1'b1;
    wb(1'b1, `OFS_SAMPLE_CLK, 32'h0000_0000);
    wb(1'b1, `OFS_LINE_PEND, 32'h0007_ffff);
    poll(32'h0000_0008);
  endtask

  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_fields();
    t_select();
    t_modes();
    t_irq();
    t_slow();
    conclude();
  end
  initial begin
    #500000;
    bad_count++;
    conclude();
  end
endmodule
